// ---- hw/ssd_pkg.sv ----
// package: constants for the servo startup and direction block
package ssd_pkg;
  // clock rate and timing figures
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned BASE_INIT_MS    = 1500;   // standard init time
  localparam int unsigned WAIT_STEP_MS    = 100;    // wait setting unit
  localparam int unsigned WAIT_SET_MAX    = 100;    // largest wait setting
  localparam int unsigned WAIT_SET_W      = 7;      // wait setting width
  // cycle counts derived from the figures
  localparam longint unsigned BASE_INIT_CYC =
    longint'(CLK_HZ) / 1000 * BASE_INIT_MS;
  localparam longint unsigned WAIT_STEP_CYC =
    longint'(CLK_HZ) / 1000 * WAIT_STEP_MS;
  // direction setting encodings
  localparam logic DIR_NORMAL  = 1'h0;   // positive -> clockwise
  localparam logic DIR_REVERSE = 1'h1;   // positive -> counterclockwise
  // sequencer states
  typedef enum logic [1:0] {
    SSD_ST_BASE = 2'b00,   // base init time running
    SSD_ST_WAIT = 2'b01,   // extra wait steps running
    SSD_ST_DONE = 2'b10    // init complete, protection on
  } ssd_state_t;
endpackage

// ---- hw/ssd_startup_dir.sv ----
// module: power-up sequencer, servo ready and direction mapping
// Functional notes
// - hold init 1.5 s plus wait times 0.1 s
// - refuse commands until init interval ends
// - ready needs init, power, no alarm, sync, link
// - protection starts after base time plus wait
// - servo-on status shows receipt, not readiness
// - direction bit swaps clockwise and counterclockwise
// - rotation judged from load-side shaft end
// - each inhibit blocks only its own direction
`timescale 1ns/1ps
module ssd_startup_dir
  import ssd_pkg::*;
#(
  parameter longint unsigned BASE_CYC = BASE_INIT_CYC,  // base init cycles
  parameter longint unsigned STEP_CYC = WAIT_STEP_CYC   // cycles per step
) (
  input  wire logic                  sys_clk,          // 250 MHz clock
  input  wire logic                  rst_b,            // async reset, low
  input  wire logic [WAIT_SET_W-1:0] power_up_wait_setting,  // 0..100
  input  wire logic                  rotation_direction_setting, // 0/1
  input  wire logic                  main_power_ok,    // main power pin
  input  wire logic                  alarm_active,     // alarm from logic
  input  wire logic                  phase_matched,    // network sync
  input  wire logic                  link_established, // network up
  input  wire logic                  servo_on_cmd,     // servo-on received
  input  wire logic                  cmd_valid,        // command present
  input  wire logic                  cmd_negative,     // command sign
  input  wire logic                  positive_overtravel_inhibit, // pin
  input  wire logic                  negative_overtravel_inhibit, // pin
  output logic                       init_done,        // init complete
  output logic                       protection_active, // monitoring on
  output logic                       servo_ready,      // ready status
  output logic                       servo_on_status,  // servo-on status
  output logic                       cmd_accept,       // command taken
  output logic                       clockwise_rotation,        // cw drive
  output logic                       counterclockwise_rotation, // ccw drive
  output logic                       motion_blocked    // inhibit stopped it
);

  localparam int CNT_W = 32;  // wide enough for 1.5 s at 250 MHz

  // elaboration checks: refuse counts the logic cannot serve
  // a zero count would wrap the end value round to the counter's top value
  if (BASE_CYC < 64'h1) begin : g_bad_base
    $error("ssd_startup_dir: BASE_CYC must be at least one");
  end
  if (STEP_CYC < 64'h1) begin : g_bad_step
    $error("ssd_startup_dir: STEP_CYC must be at least one");
  end
  // both counts must fit the cycle counter, or the end value is cut short and matches early
  if (BASE_CYC > (64'h1 << CNT_W)) begin : g_big_base
    $error("ssd_startup_dir: BASE_CYC too large for the counter");
  end
  if (STEP_CYC > (64'h1 << CNT_W)) begin : g_big_step
    $error("ssd_startup_dir: STEP_CYC too large for the counter");
  end
  // the clamp value must fit the wait setting port and step counter
  if (WAIT_SET_MAX >= (32'h1 << WAIT_SET_W)) begin : g_bad_wait
    $error("ssd_startup_dir: wait setting too narrow for its range");
  end

  logic [1:0]        rst_sync_q;   // reset release synchroniser
  logic              rst_n;        // synchronised reset
  // synchroniser first stages feed only their second stages
  logic [1:0]        pwr_sync_q;   // main power synchroniser
  logic [1:0]        pot_sync_q;   // positive inhibit synchroniser
  logic [1:0]        not_sync_q;   // negative inhibit synchroniser
  ssd_state_t        state_q;      // sequencer state
  logic [CNT_W-1:0]  cnt_q;        // cycle counter
  logic [WAIT_SET_W-1:0] steps_q;  // wait steps left
  logic              ready_q;      // registered ready
  logic              son_q;        // registered servo-on status
  logic              cw_q;         // registered cw output
  logic              ccw_q;        // registered ccw output
  logic              blk_q;        // registered block flag
  logic              acc_q;        // registered accept
  logic [WAIT_SET_W-1:0] wait_clip; // wait setting clamped to range
  logic              dir_pos;      // command asks positive direction
  logic              inhibit_hit;  // inhibit matching direction

  // reset release through two flops
  // assertion is asynchronous so the block clears even without a clock;
  // release is synchronous so no flop sees it close to a clock edge
  // everything below runs from the released copy, rst_n
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_q <= 2'h0;
    else        rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_n = rst_sync_q[1];

  // pin inputs pass two flops
  // power good and both inhibits arrive from pins with no clock relation;
  // only the second stage is read, so no logic sees a metastable level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_sync_q <= 2'h0;
      pot_sync_q <= 2'h0;
      not_sync_q <= 2'h0;
    end else begin
      pwr_sync_q <= {pwr_sync_q[0], main_power_ok};
      pot_sync_q <= {pot_sync_q[0], positive_overtravel_inhibit};
      not_sync_q <= {not_sync_q[0], negative_overtravel_inhibit};
    end
  end

  // clamp wait setting to its legal range
  // values above the top of the range act as the top value, so a stray
  // setting can never stretch init beyond its worst case
  assign wait_clip = (power_up_wait_setting > WAIT_SET_W'(WAIT_SET_MAX)) ?
                     WAIT_SET_W'(WAIT_SET_MAX) : power_up_wait_setting;

  // init sequencer: base time then setting x step
  // the setting is taken once, when the base time ends, so a host that
  // rewrites it during init cannot shorten an interval already begun
  // one counter serves both phases; it restarts at zero for each step
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SSD_ST_BASE;
      cnt_q   <= '0;
      steps_q <= '0;
    end else begin
      // fixed codes; a stray code falls into the default branch
      case (state_q)
        // a zero setting skips the wait phase entirely
        SSD_ST_BASE: begin  // base 1.5 s
          if (cnt_q == CNT_W'(BASE_CYC - 1)) begin
            cnt_q   <= '0;
            steps_q <= wait_clip;  // setting taken at end of base time
            state_q <= (wait_clip == '0) ? SSD_ST_DONE : SSD_ST_WAIT;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        // one counted step per setting unit; leave as the last one ends
        SSD_ST_WAIT: begin  // wait lengthens init
          if (cnt_q == CNT_W'(STEP_CYC - 1)) begin
            cnt_q   <= '0;
            steps_q <= steps_q - WAIT_SET_W'(1);
            if (steps_q == WAIT_SET_W'(1)) state_q <= SSD_ST_DONE;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        SSD_ST_DONE: begin  // stays here until reset
          cnt_q <= '0;
        end
        default: begin  // recover to start
          state_q <= SSD_ST_BASE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // init done also starts protection monitoring
  // both points share one instant, as the wait setting lengthens both;
  // monitoring then stays on until the next reset
  assign init_done         = (state_q == SSD_ST_DONE);
  assign protection_active = (state_q == SSD_ST_DONE);

  // servo ready from all conditions, drops a cycle after any one fails
  // registered AND: one cycle late both ways, but glitch free for the
  // host; power good adds its two synchroniser cycles on top
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ready_q <= 1'h0;
    else ready_q <= init_done && pwr_sync_q[1] && !alarm_active &&
                    phase_matched && link_established;
  end
  assign servo_ready = ready_q;

  // servo-on status only echoes receipt
  // it follows the command even before init ends; it never implies
  // that the drive will take motion commands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) son_q <= 1'h0;
    else        son_q <= servo_on_cmd;
  end
  assign servo_on_status = son_q;

  // direction of the command in the positive sense
  // only the sign matters here; magnitude is handled upstream
  assign dir_pos = !cmd_negative;
  // each inhibit guards its own direction only
  assign inhibit_hit = dir_pos ? pot_sync_q[1] : not_sync_q[1];

  // command acceptance and rotation mapping
  // an inhibited command still counts as taken, but no rotation is
  // requested and motion_blocked reports why
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 1'h0;
      cw_q  <= 1'h0;
      ccw_q <= 1'h0;
      blk_q <= 1'h0;
    end else begin
      acc_q <= cmd_valid && init_done;  // refused during init
      blk_q <= cmd_valid && init_done && inhibit_hit;
      if (cmd_valid && init_done && !inhibit_hit) begin
        // cw/ccw as seen at load-side shaft end
        if (rotation_direction_setting == DIR_NORMAL) begin
          cw_q  <= dir_pos;
          ccw_q <= !dir_pos;
        end else begin  // reversed mapping
          cw_q  <= !dir_pos;
          ccw_q <= dir_pos;
        end
      end else begin  // no motion
        cw_q  <= 1'h0;
        ccw_q <= 1'h0;
      end
    end
  end
  assign cmd_accept                = acc_q;
  assign clockwise_rotation        = cw_q;
  assign counterclockwise_rotation = ccw_q;
  assign motion_blocked            = blk_q;

  // limitation: the over-travel status bit layout seen by the host is
  // not rearranged here when the direction bit changes; inputs that can
  // trip protection must be settled before init_done rises

endmodule

// ---- dv/ssd_startup_dir_sva.sv ----
// checker: port timing of the startup and direction block
`timescale 1ns/1ps
module ssd_chk (
  input wire logic sys_clk,                    // block clock
  input wire logic rst_b,                      // async reset, low
  input wire logic init_done,                  // init over
  input wire logic protection_active,          // monitoring on
  input wire logic alarm_active,               // alarm condition
  input wire logic phase_matched,              // network sync
  input wire logic link_established,           // network up
  input wire logic servo_ready,                // ready status
  input wire logic servo_on_cmd,               // servo-on received
  input wire logic servo_on_status,            // servo-on status
  input wire logic cmd_valid,                  // command present
  input wire logic cmd_negative,               // command sign
  input wire logic rotation_direction_setting, // direction bit
  input wire logic cmd_accept,                 // command taken
  input wire logic clockwise_rotation,         // cw drive
  input wire logic counterclockwise_rotation,  // ccw drive
  input wire logic motion_blocked              // inhibit stopped it
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_acc; cmd_accept == ($past(cmd_valid) && $past(init_done));
  endproperty
  a_acc: assert property (p_acc) else $error("accept");
  property p_rdy; servo_ready |-> $past(init_done) && $past(phase_matched)
    && $past(link_established) && !$past(alarm_active); endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_alm; alarm_active |=> !servo_ready; endproperty
  a_alm: assert property (p_alm) else $error("alarm");
  property p_son; init_done |-> servo_on_status == $past(servo_on_cmd);
  endproperty
  a_son: assert property (p_son) else $error("servo on");
  property p_cw; clockwise_rotation |-> cmd_accept &&
    $past(cmd_negative) == $past(rotation_direction_setting); endproperty
  a_cw: assert property (p_cw) else $error("cw");
  property p_ccw; counterclockwise_rotation |-> cmd_accept &&
    $past(cmd_negative) != $past(rotation_direction_setting); endproperty
  a_ccw: assert property (p_ccw) else $error("ccw");
  property p_mb; motion_blocked |-> cmd_accept && !clockwise_rotation &&
    !counterclockwise_rotation; endproperty
  a_mb: assert property (p_mb) else $error("blocked");
  // monitoring starts with init done and stays on until reset
  property p_prot; (protection_active == init_done) and
    (protection_active |=> protection_active); endproperty
  a_prot: assert property (p_prot) else $error("protect");
endmodule
bind ssd_startup_dir ssd_chk u_chk (.*);

// ---- dv/ssd_host_model.sv ----
// host model: sends motion commands once the drive is initialised, or during init when early is set
`timescale 1ns/1ps
module ssd_host_model (
  input wire logic sys_clk,     // shared clock
  input wire logic init_done,   // drive init over
  input wire logic req,         // one command wanted
  input wire logic neg,         // its sign
  input wire logic early,       // send during init anyway
  output logic     cmd_valid,   // command present
  output logic     cmd_negative // sign, toggles when idle
);
  initial cmd_valid = 1'h0;
  initial cmd_negative = 1'h0;
  // waits out init unless told to misbehave
  always @(posedge sys_clk) begin
    cmd_valid <= #1 req && (init_done || early);
    cmd_negative <= #1 req ? neg : !cmd_negative;
  end
endmodule

// ---- dv/ssd_startup_dir_bench.sv ----
// bench: init timing, readiness and direction mapping
`timescale 1ns/1ps
module servo_startup_and_direction_bench;
  logic [6:0] power_up_wait_setting;
  logic [3:0] cnd;
  logic sys_clk, rst_b, rotation_direction_setting, main_power_ok;
  logic alarm_active, phase_matched, link_established, servo_on_cmd;
  logic cmd_valid, cmd_negative, init_done, protection_active, servo_ready;
  logic positive_overtravel_inhibit, negative_overtravel_inhibit;
  logic servo_on_status, cmd_accept, clockwise_rotation, motion_blocked;
  logic counterclockwise_rotation, req, neg, early;
  int err_count = 0, total_checks = 0;
  assign {main_power_ok, alarm_active, phase_matched, link_established} = cnd;
  ssd_startup_dir #(.BASE_CYC(20), .STEP_CYC(5)) dut_u (.*);
  ssd_host_model host_u (.*);
  initial begin sys_clk = 0; forever #2 sys_clk = !sys_clk; end
  task cyc(input int n); repeat (n) @(posedge sys_clk); #1; endtask
  task chk(input string s, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_count++; $display("ERROR %s exp %b got %b", s, e, g); end
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reset, time init while a premature command waits
  task t_init(input logic [6:0] s, input int e);
    int n; logic bad;
    n = 0; bad = 0; rst_b = 0; power_up_wait_setting = s; req = 1; early = 1;
    cyc(4); rst_b = 1;
    while (init_done !== 1 && n < e + 8) begin
      bad |= cmd_accept; cyc(1); n++; end
    req = 0; early = 0;
    chk("init_len", 1, n > e && n < e + 5);
    chk("protect", 1, protection_active);
    chk("refused", 0, bad);
    if (n >= e + 8) summarize();
  endtask
  // drop the power, no-alarm, sync and link ready conditions in turn
  task t_ready;
    for (int k = 0; k < 4; k++) begin
      cyc(4); chk("ready", 1, servo_ready);
      servo_on_cmd = k[0]; cnd = 4'hB ^ (4'h8 >> k); cyc(4);
      chk("not_ready", 0, servo_ready);
      chk("servo_on", k[0], servo_on_status);
      cnd = 4'hB;
    end
  endtask
  // every direction and sign, with no inhibit or one inhibit at a time
  task t_dir;
    logic b;
    for (int i = 0; i < 12; i++) begin
      rotation_direction_setting = i[0]; // host owns bit layout
      {negative_overtravel_inhibit, positive_overtravel_inhibit} = i[3:2];
      cyc(4); req = 1; neg = i[1]; cyc(1); req = 0; cyc(1);
      b = i[2] & !i[1] | i[3] & i[1];
      chk("cw", !b && i[1] == i[0], clockwise_rotation);
      chk("ccw", !b && i[1] != i[0], counterclockwise_rotation);
      chk("blocked", b, motion_blocked);
      chk("accept", 1, cmd_accept);
    end
  endtask
  initial begin
    rst_b = 0; cnd = 4'hB; servo_on_cmd = 0; req = 0; neg = 0; early = 0;
    power_up_wait_setting = 0; rotation_direction_setting = 0;
    positive_overtravel_inhibit = 0; negative_overtravel_inhibit = 0;
    t_init(3, 35); t_ready; t_dir; t_init(0, 20); t_init(127, 520);
    summarize;
  end
endmodule
